// *** verilog/fpdwp_consts.svh ***
// constants for the flash program data and write-protect block
`ifndef FPDWP_CONSTS_SVH
`define FPDWP_CONSTS_SVH

// register offsets (byte addresses, one aligned word each)
`define FPDWP_OFF_DATA_LO 8'h00
`define FPDWP_OFF_DATA_HI 8'h04
`define FPDWP_OFF_SRC 8'h08
`define FPDWP_OFF_PWP 8'h0C
`define FPDWP_OFF_STATUS 8'h10

// protect register layout
`define FPDWP_PWP_UNLOCK_BIT 31
`define FPDWP_PWP_FIELD_MSB 23
`define FPDWP_PWP_FIELD_W 24
`define FPDWP_PWP_RESET 32'h80000000
`define FPDWP_WORD_RESET 32'h00000000
`define FPDWP_FIELD_RESET 24'h000000

// status register layout
`define FPDWP_ST_BLOCKED_BIT 0
`define FPDWP_ST_DONE_BIT 1
`define FPDWP_ST_OP_LSB 4

// flash address map
`define FPDWP_FLASH_UPPER 8'h1D
`define FPDWP_PAGE_BITS 11
`define FPDWP_ROW_BITS 8
`define FPDWP_DW_BITS 3

// operation codes
`define FPDWP_OP_DWORD 4'h2
`define FPDWP_OP_ROW 4'h3
`define FPDWP_OP_PAGE_ERASE 4'h4
`define FPDWP_OP_CHIP_ERASE 4'h7

`endif

// *** verilog/fpdwp_pkg.sv ***
// types shared by the flash program data and write-protect block
`default_nettype none
package fpdwp_pkg;

  typedef logic [31:0] fpdwp_word_t;

  typedef enum logic [1:0] {
    FPDWP_IDLE,
    FPDWP_ISSUE
  } fpdwp_state_e;

endpackage
`default_nettype wire

// *** verilog/fpdwp_protect_check.sv ***
// page write-protect comparison against the boundary field
`timescale 1ns/100ps
`default_nettype none
`include "fpdwp_consts.svh"

module fpdwp_protect_check
  import fpdwp_pkg::*;
(
  input wire logic [`FPDWP_PWP_FIELD_W-1:0] boundary_in,
  input wire fpdwp_word_t addr_in,
  input wire logic whole_in,
  output logic protected_out
);

  logic [32:0] base;
  logic [32:0] top;
  logic partial;

  // ****************************************************************
  // boundary rounded up to the end of the page it falls in
  // ****************************************************************
  always_comb begin
    base = {1'b0, `FPDWP_FLASH_UPPER, boundary_in[`FPDWP_PWP_FIELD_W-1:`FPDWP_PAGE_BITS],
            {`FPDWP_PAGE_BITS{1'b0}}};
    partial = |boundary_in[`FPDWP_PAGE_BITS-1:0];
    top = base + (partial ? (33'h1 << `FPDWP_PAGE_BITS) : 33'h0);
    if (boundary_in == '0) begin
      protected_out = 1'b0;
    end else if (whole_in) begin
      // a whole erase needs every page unprotected
      protected_out = 1'b1;
    end else begin
      protected_out = ({1'b0, addr_in} < top);
    end
  end

endmodule // fpdwp_protect_check
`default_nettype wire

// *** verilog/fpdwp_top.sv ***
// flash program data, source address and page write-protect registers
// Behaviour
// - double-word writes high:low data to target
// - data, source, protect cleared only by power-on
// - row program fetches from source address register
// - protect register frozen once unlock bit clear
// - unlock bit only clearable; any reset sets
// - addresses below 0x1D boundary are protected
// - zero boundary field disables all protection
// - partial page boundary protects whole page
// - protect writes need completed key unlock
// - protect bits 30 to 24 read zero
// - opcodes 2 dword, 3 row, 4 page, 7 whole
// - dword ignores target address bits 2..0
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "fpdwp_consts.svh"

module fpdwp_top
  import fpdwp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic por_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic key_unlocked_in,
  input wire logic op_start_in,
  input wire logic [3:0] flash_operation_code_in,
  input wire logic [31:0] flash_target_address_in,
  output logic flash_wr_out,
  output logic [31:0] flash_wr_addr_out,
  output logic [63:0] flash_wr_data_out,
  output logic row_fetch_out,
  output logic [31:0] row_fetch_addr_out,
  output logic page_erase_out,
  output logic chip_erase_out,
  output logic op_blocked_out
);

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  logic any_rst;
  assign any_rst = !rst_n_in || !por_n_in;

  logic wr_lo;
  logic wr_hi;
  logic wr_src;
  logic wr_pwp;
  logic wr_st;
  assign wr_lo = reg_wr_in && hit(reg_addr_in, `FPDWP_OFF_DATA_LO);
  assign wr_hi = reg_wr_in && hit(reg_addr_in, `FPDWP_OFF_DATA_HI);
  assign wr_src = reg_wr_in && hit(reg_addr_in, `FPDWP_OFF_SRC);
  assign wr_pwp = reg_wr_in && hit(reg_addr_in, `FPDWP_OFF_PWP);
  assign wr_st = reg_wr_in && hit(reg_addr_in, `FPDWP_OFF_STATUS);

  // ****************************************************************
  // data words and source address
  // ****************************************************************
  fpdwp_word_t data_q [2];
  fpdwp_word_t src_q;
  logic [1:0] wr_data;
  assign wr_data = {wr_hi, wr_lo};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_data
      // only power-on clears these; system reset leaves them alone
      always_ff @(posedge clk_in) begin
        if (!por_n_in) begin
          data_q[gi] <= `FPDWP_WORD_RESET;
        end else if (wr_data[gi]) begin
          data_q[gi] <= reg_wdata_in;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_in) begin
    if (!por_n_in) begin
      src_q <= `FPDWP_WORD_RESET;
    end else if (wr_src) begin
      src_q <= reg_wdata_in;
    end
  end

  // ****************************************************************
  // write-protect register
  // ****************************************************************
  logic unlock_q;
  logic [`FPDWP_PWP_FIELD_W-1:0] field_q;
  logic pwp_we;
  assign pwp_we = wr_pwp && key_unlocked_in && unlock_q;

  // any reset reopens the register, writes may only close it
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      unlock_q <= 1'b1;
    end else if (pwp_we && !reg_wdata_in[`FPDWP_PWP_UNLOCK_BIT]) begin
      unlock_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!por_n_in) begin
      field_q <= `FPDWP_FIELD_RESET;
    end else if (pwp_we) begin
      field_q <= reg_wdata_in[`FPDWP_PWP_FIELD_MSB:0];
    end
  end

  // ****************************************************************
  // protection check and operation sequencing
  // ****************************************************************
  logic prot_c;
  fpdwp_protect_check u_check (
    .boundary_in(field_q),
    .addr_in(flash_target_address_in),
    .whole_in(flash_operation_code_in == `FPDWP_OP_CHIP_ERASE),
    .protected_out(prot_c)
  );

  fpdwp_state_e state_q;
  logic [3:0] op_q;
  fpdwp_word_t addr_q;
  logic prot_q;
  logic known_op;
  assign known_op = (flash_operation_code_in == `FPDWP_OP_DWORD) ||
                    (flash_operation_code_in == `FPDWP_OP_ROW) ||
                    (flash_operation_code_in == `FPDWP_OP_PAGE_ERASE) ||
                    (flash_operation_code_in == `FPDWP_OP_CHIP_ERASE);

  // starts while a request is issuing are dropped
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      state_q <= FPDWP_IDLE;
    end else begin
      case (state_q)
        FPDWP_IDLE: begin
          if (op_start_in && known_op) begin
            state_q <= FPDWP_ISSUE;
          end
        end
        FPDWP_ISSUE: begin
          state_q <= FPDWP_IDLE;
        end
        default: begin
          state_q <= FPDWP_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      op_q <= 4'h0;
      addr_q <= 32'h00000000;
      prot_q <= 1'b0;
    end else if (state_q == FPDWP_IDLE && op_start_in) begin
      op_q <= flash_operation_code_in;
      addr_q <= flash_target_address_in;
      prot_q <= prot_c;
    end
  end

  // ****************************************************************
  // flash request outputs, one-cycle pulses
  // ****************************************************************
  logic go;
  assign go = (state_q == FPDWP_ISSUE) && !prot_q;

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      flash_wr_out <= 1'b0;
      row_fetch_out <= 1'b0;
      page_erase_out <= 1'b0;
      chip_erase_out <= 1'b0;
    end else begin
      flash_wr_out <= go && (op_q == `FPDWP_OP_DWORD);
      row_fetch_out <= go && (op_q == `FPDWP_OP_ROW);
      page_erase_out <= go && (op_q == `FPDWP_OP_PAGE_ERASE);
      chip_erase_out <= go && (op_q == `FPDWP_OP_CHIP_ERASE);
    end
  end

  // address and data hold their values between requests
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      flash_wr_addr_out <= 32'h00000000;
      flash_wr_data_out <= 64'h0000000000000000;
      row_fetch_addr_out <= 32'h00000000;
    end else if (go) begin
      case (op_q)
        `FPDWP_OP_DWORD: begin
          flash_wr_addr_out <= {addr_q[31:`FPDWP_DW_BITS], {`FPDWP_DW_BITS{1'b0}}};
          flash_wr_data_out <= {data_q[1], data_q[0]};
        end
        `FPDWP_OP_ROW: begin
          flash_wr_addr_out <= {addr_q[31:`FPDWP_ROW_BITS], {`FPDWP_ROW_BITS{1'b0}}};
          row_fetch_addr_out <= src_q;
        end
        `FPDWP_OP_PAGE_ERASE: begin
          flash_wr_addr_out <= {addr_q[31:`FPDWP_PAGE_BITS], {`FPDWP_PAGE_BITS{1'b0}}};
        end
        default: begin
          flash_wr_addr_out <= flash_wr_addr_out;
        end
      endcase
    end
  end

  // ****************************************************************
  // status: sticky blocked flag, a new block wins over a clear
  // ****************************************************************
  logic blocked_q;
  logic done_q;
  logic [3:0] last_op_q;

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      blocked_q <= 1'b0;
    end else if (state_q == FPDWP_ISSUE && prot_q) begin
      blocked_q <= 1'b1;
    end else if (wr_st && reg_wdata_in[`FPDWP_ST_BLOCKED_BIT]) begin
      blocked_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      done_q <= 1'b0;
      last_op_q <= 4'h0;
    end else if (state_q == FPDWP_ISSUE) begin
      done_q <= !prot_q;
      last_op_q <= op_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      op_blocked_out <= 1'b0;
    end else begin
      op_blocked_out <= blocked_q;
    end
  end

  // ****************************************************************
  // read port, data in the cycle after the strobe
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (any_rst) begin
      reg_rdata_out <= 32'h00000000;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `FPDWP_OFF_DATA_LO: reg_rdata_out <= data_q[0];
        `FPDWP_OFF_DATA_HI: reg_rdata_out <= data_q[1];
        `FPDWP_OFF_SRC: reg_rdata_out <= src_q;
        `FPDWP_OFF_PWP: reg_rdata_out <= {unlock_q, 7'h00, field_q};
        `FPDWP_OFF_STATUS: reg_rdata_out <= {24'h000000, last_op_q, 2'h0, done_q, blocked_q};
        default: reg_rdata_out <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_out <= 32'h00000000;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_dword_data: assert property (@(posedge clk_in) disable iff (any_rst)
    (go && op_q == `FPDWP_OP_DWORD) |=>
      flash_wr_out && flash_wr_data_out == {$past(data_q[1]), $past(data_q[0])})
    else $error("double-word data not high:low");

  a_data_keep: assert property (@(posedge clk_in) disable iff (!por_n_in)
    (!rst_n_in && !wr_lo && !wr_hi) |=> $stable(data_q[0]) && $stable(data_q[1]))
    else $error("data words changed by system reset");

  a_row_source: assert property (@(posedge clk_in) disable iff (any_rst)
    row_fetch_out |-> row_fetch_addr_out == $past(src_q))
    else $error("row fetch address is not the source address");

  a_locked_frozen: assert property (@(posedge clk_in) disable iff (!por_n_in)
    (!unlock_q && rst_n_in) |=> $stable(field_q))
    else $error("protect field changed while locked");

  a_unlock_one_way: assert property (@(posedge clk_in) disable iff (!por_n_in)
    (rst_n_in && $past(rst_n_in)) |-> !$rose(unlock_q))
    else $error("unlock bit set without reset");

  a_prot_blocks: assert property (@(posedge clk_in) disable iff (any_rst)
    (state_q == FPDWP_IDLE && op_start_in && known_op && prot_c) |-> ##2
      (!flash_wr_out && !row_fetch_out && !page_erase_out && !chip_erase_out && blocked_q))
    else $error("protected target was modified");

  a_zero_field: assert property (@(posedge clk_in) disable iff (any_rst)
    (field_q == '0) |-> !prot_c)
    else $error("zero boundary still protects");

  a_nokey_ignored: assert property (@(posedge clk_in) disable iff (any_rst)
    (wr_pwp && !key_unlocked_in) |=> $stable(field_q) && $stable(unlock_q))
    else $error("protect write taken without key");

  a_reserved_zero: assert property (@(posedge clk_in) disable iff (any_rst)
    (reg_rd_in && reg_addr_in == `FPDWP_OFF_PWP) |=> reg_rdata_out[30:24] == 7'h00)
    else $error("protect reserved bits not zero");

  a_dword_align: assert property (@(posedge clk_in) disable iff (any_rst)
    flash_wr_out |-> flash_wr_addr_out[2:0] == 3'h0)
    else $error("double-word address not aligned");

  a_below_boundary: assert property (@(posedge clk_in) disable iff (any_rst)
    (field_q != '0 && flash_target_address_in[31:`FPDWP_PAGE_BITS] <
      {`FPDWP_FLASH_UPPER, field_q[`FPDWP_PWP_FIELD_MSB:`FPDWP_PAGE_BITS]}) |-> prot_c)
    else $error("page below boundary not protected");

  a_partial_page: assert property (@(posedge clk_in) disable iff (any_rst)
    (field_q[`FPDWP_PAGE_BITS-1:0] != '0 && flash_target_address_in[31:`FPDWP_PAGE_BITS] ==
      {`FPDWP_FLASH_UPPER, field_q[`FPDWP_PWP_FIELD_MSB:`FPDWP_PAGE_BITS]}) |-> prot_c)
    else $error("boundary page not protected");

  a_above_open: assert property (@(posedge clk_in) disable iff (any_rst)
    (flash_operation_code_in != `FPDWP_OP_CHIP_ERASE && flash_target_address_in[31:`FPDWP_PAGE_BITS] >
      {`FPDWP_FLASH_UPPER, field_q[`FPDWP_PWP_FIELD_MSB:`FPDWP_PAGE_BITS]}) |-> !prot_c)
    else $error("page above boundary protected");

  a_unknown_op: assert property (@(posedge clk_in) disable iff (any_rst)
    (state_q == FPDWP_IDLE && op_start_in && !known_op) |-> ##2
      (!flash_wr_out && !row_fetch_out && !page_erase_out && !chip_erase_out))
    else $error("reserved opcode started a request");

  a_row_align: assert property (@(posedge clk_in) disable iff (any_rst)
    row_fetch_out |-> flash_wr_addr_out[`FPDWP_ROW_BITS-1:0] == 8'h00)
    else $error("row address not aligned");

endmodule // fpdwp_top
`default_nettype wire

// *** bench/fpdwp_tb_top.sv ***
// self-checking testbench for the flash program data and write-protect block
`timescale 1ns/100ps
`default_nettype none
`include "fpdwp_consts.svh"

module fpdwp_tb_top
  import fpdwp_pkg::*;
;
  // ****************
  // signals and dut
  // ****************
  logic clk_in;
  logic rst_n_in;
  logic por_n_in;
  logic [7:0] reg_addr_in;
  logic [31:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [31:0] reg_rdata_out;
  logic key_unlocked_in;
  logic op_start_in;
  logic [3:0] flash_operation_code_in;
  logic [31:0] flash_target_address_in;
  logic flash_wr_out;
  logic [31:0] flash_wr_addr_out;
  logic [63:0] flash_wr_data_out;
  logic row_fetch_out;
  logic [31:0] row_fetch_addr_out;
  logic page_erase_out;
  logic chip_erase_out;
  logic op_blocked_out;
  int num_errors;
  int tests_run;

  fpdwp_top u_dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .por_n_in(por_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .key_unlocked_in(key_unlocked_in),
    .op_start_in(op_start_in),
    .flash_operation_code_in(flash_operation_code_in),
    .flash_target_address_in(flash_target_address_in),
    .flash_wr_out(flash_wr_out),
    .flash_wr_addr_out(flash_wr_addr_out),
    .flash_wr_data_out(flash_wr_data_out),
    .row_fetch_out(row_fetch_out),
    .row_fetch_addr_out(row_fetch_addr_out),
    .page_erase_out(page_erase_out),
    .chip_erase_out(chip_erase_out),
    .op_blocked_out(op_blocked_out)
  );

  always #5 clk_in = ~clk_in;

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // por selects power-on reset as well as the system reset
  task automatic do_reset(input logic por);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    por_n_in <= ~por;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    por_n_in <= 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1;
    chk({32'h00000000, reg_rdata_out}, {32'h00000000, exp});
  endtask

  // pulses = {dword, row, page erase, whole erase}, seen two cycles after start
  task automatic run_op(input logic [3:0] op, input logic [31:0] a, input logic [3:0] pulses, input logic blk);
    @(posedge clk_in);
    op_start_in <= 1'b1;
    flash_operation_code_in <= op;
    flash_target_address_in <= a;
    @(posedge clk_in);
    op_start_in <= 1'b0;
    @(posedge clk_in);
    #1;
    chk({60'h0, flash_wr_out, row_fetch_out, page_erase_out, chip_erase_out}, {60'h0, pulses});
    @(posedge clk_in);
    #1;
    chk({60'h0, flash_wr_out, row_fetch_out, page_erase_out, chip_erase_out}, 64'h0000000000000000);
    chk({63'h0, op_blocked_out}, {63'h0, blk});
  endtask

  // ****************
  // main sequence
  // ****************
  initial begin
    clk_in = 1'b0;
    rst_n_in = 1'b0;
    por_n_in = 1'b0;
    reg_addr_in = 8'h00;
    reg_wdata_in = 32'h00000000;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    key_unlocked_in = 1'b0;
    op_start_in = 1'b0;
    flash_operation_code_in = 4'h0;
    flash_target_address_in = 32'h00000000;
    num_errors = 0;
    tests_run = 0;
    do_reset(1'b1);
    rd_chk(`FPDWP_OFF_DATA_LO, 32'h00000000);
    rd_chk(`FPDWP_OFF_SRC, 32'h00000000);
    rd_chk(`FPDWP_OFF_PWP, 32'h80000000);
    wr(`FPDWP_OFF_DATA_LO, 32'h11223344);
    wr(`FPDWP_OFF_DATA_HI, 32'h55667788);
    wr(`FPDWP_OFF_SRC, 32'h0000A000);
    wr(`FPDWP_OFF_PWP, 32'h00000900);
    rd_chk(`FPDWP_OFF_PWP, 32'h80000000);
    key_unlocked_in <= 1'b1;
    wr(`FPDWP_OFF_PWP, 32'hFF000900);
    rd_chk(`FPDWP_OFF_PWP, 32'h80000900);
    run_op(`FPDWP_OP_PAGE_ERASE, 32'h1D000F00, 4'b0000, 1'b1);
    wr(`FPDWP_OFF_STATUS, 32'h00000001);
    run_op(`FPDWP_OP_PAGE_ERASE, 32'h1D001000, 4'b0010, 1'b0);
    chk({32'h0, flash_wr_addr_out}, {32'h0, 32'h1D001000});
    run_op(`FPDWP_OP_DWORD, 32'h1D002007, 4'b1000, 1'b0);
    chk({32'h0, flash_wr_addr_out}, {32'h0, 32'h1D002000});
    chk(flash_wr_data_out, 64'h5566778811223344);
    rd_chk(`FPDWP_OFF_STATUS, 32'h00000022);
    run_op(`FPDWP_OP_ROW, 32'h1D0021FF, 4'b0100, 1'b0);
    chk({32'h0, row_fetch_addr_out}, {32'h0, 32'h0000A000});
    chk({32'h0, flash_wr_addr_out}, {32'h0, 32'h1D002100});
    run_op(`FPDWP_OP_CHIP_ERASE, 32'h1D000000, 4'b0000, 1'b1);
    run_op(4'h5, 32'h1D004000, 4'b0000, 1'b1);
    wr(`FPDWP_OFF_PWP, 32'h00000900);
    rd_chk(`FPDWP_OFF_PWP, 32'h00000900);
    wr(`FPDWP_OFF_PWP, 32'h80000000);
    rd_chk(`FPDWP_OFF_PWP, 32'h00000900);
    key_unlocked_in <= 1'b0;
    // system reset keeps the words but restores the unlock bit
    do_reset(1'b0);
    rd_chk(`FPDWP_OFF_PWP, 32'h80000900);
    rd_chk(`FPDWP_OFF_DATA_HI, 32'h55667788);
    rd_chk(`FPDWP_OFF_SRC, 32'h0000A000);
    do_reset(1'b1);
    rd_chk(`FPDWP_OFF_PWP, 32'h80000000);
    rd_chk(`FPDWP_OFF_DATA_LO, 32'h00000000);
    run_op(`FPDWP_OP_CHIP_ERASE, 32'h1D000000, 4'b0001, 1'b0);
    run_op(`FPDWP_OP_DWORD, 32'h1D000000, 4'b1000, 1'b0);
    chk(flash_wr_data_out, 64'h0000000000000000);
    stop_test();
  end

  // guards against a hung sequence
  initial begin
    repeat (5000) @(posedge clk_in);
    num_errors++;
    stop_test();
  end

endmodule // fpdwp_tb_top
`default_nettype wire
